//--- include/vic_defines.svh
// Purpose: Offsets, field positions, reset values and vectors of the interrupt control
// Assumes: 32-bit AHB-Lite register words, one word per register
// Notes:   Included by bare name
`ifndef VIC_DEFINES_SVH
`define VIC_DEFINES_SVH
// ==========================================================================
// Register offsets
`define VIC_OFF_EXT_SENS   8'h00
`define VIC_OFF_PIN_EN     8'h04
`define VIC_OFF_PERIPH_EN  8'h08
`define VIC_OFF_PERIPH_FLG 8'h0C
`define VIC_OFF_STATUS     8'h10
// ==========================================================================
// Reset values
`define VIC_RST_EXT_SENS   8'h00
`define VIC_RST_PIN_EN     16'h0000
`define VIC_RST_PERIPH_EN  7'h00
// ==========================================================================
// Sensitivity codes, two bits per external group
`define VIC_SENS_FALL      2'h0
`define VIC_SENS_RISE      2'h1
`define VIC_SENS_BOTH      2'h2
`define VIC_SENS_LOW       2'h3
// ==========================================================================
// Vector numbers and addresses
`define VIC_VEC_CLK        4'h1
`define VIC_VEC_EXT0       4'h2
`define VIC_VEC_EXT3       4'h5
`define VIC_VEC_TRAP       4'hF
`define VIC_VEC_NONE       4'h0
`define VIC_ADDR_RESET     16'hFFFE
`define VIC_ADDR_TRAP      16'hFFFC
`define VIC_ADDR_BASE      16'hFFFA
`define VIC_UNUSED_SLOTS   14'h3041
// ==========================================================================
// Index of the last push in a stack frame, counted from zero
`define VIC_FRAME_LAST     3'h4
`endif

//--- include/vic_pkg.sv
// Purpose: Types of the interrupt control
// Assumes: Nothing
// Notes:   Constants live in vic_defines.svh
`default_nettype none
package vic_pkg;
    typedef enum logic [1:0] {
        VIC_IDLE,
        VIC_PUSH,
        VIC_VECT,
        VIC_POP
    } vic_state_type;
endpackage
`default_nettype wire

//--- hdl/vic_top.sv
// Purpose: Vectored interrupt control with AHB-Lite register slave
// Assumes: Core pulses instr_end at each instruction boundary, and holds it high while stopped
// Notes:   Stack data is moved by the core; this block sequences pushes, pops and vectors
//
// What this block does
// - Maskable requests are taken only while the global mask bit is clear.
// - Requests arriving while masked stay pending and are taken once unmasked.
// - After reset the mask bit is set and every enable is cleared.
// - Entry waits for the current instruction to finish.
// - Entry pushes program counter, index, accumulator and condition code.
// - Entry sets the global mask bit.
// - After stacking, the program counter loads the selected vector address.
// - Return pops the frame, clears the mask bit and resumes the program.
// - Fixed priority: trap first, then lower vector number wins among pending requests.
// - Trap enters regardless of mask; trap and reset use the top vector pairs.
// - Time-base and clock safety share vector 1, top maskable, halt-capable.
// - External groups 0 to 3 use vectors 2 to 5, descending priority.
// - Peripheral sources 2 to 6 use vectors 7 to 11 and never wake from halt.
// - Any source but trap wakes the core from wait.
// - Only external and halt-capable sources wake from halt; trap cannot.
// - Vector 1 wakes from active-halt only, not from full halt.
// - Each external group has a selectable sensitivity field.
// - Edge requests are latched and cleared when their vector is entered.
// - Enabled pins of one group are NAND-combined before detection.
// - A low enabled pin masks the combined request, even for rising edges.
// - Peripheral request needs flag and enable; otherwise it stays pending.
// - Writing zero or the clear sequence drops the flag and its pending request.
`include "vic_defines.svh"
`default_nettype none
module vic_top #(
    parameter int GROUPS    = 4,
    parameter int GRP_PINS  = 4,
    parameter int PERIPHS   = 7
) (
    // Clock and reset
    input  wire logic                         core_clk,
    input  wire logic                         arst_n,
    // AHB-Lite slave
    input  wire logic                         hsel,
    input  wire logic [7:0]                   haddr,
    input  wire logic [1:0]                   htrans,
    input  wire logic                         hwrite,
    input  wire logic [2:0]                   hsize,
    input  wire logic [31:0]                  hwdata,
    input  wire logic                         hready,
    output logic                              hreadyout,
    output logic                              hresp,
    output logic [31:0]                       hrdata,
    // Processor core
    input  wire logic                         instr_end,
    input  wire logic                         trap_exec,
    input  wire logic                         return_from_irq_instr_exec,
    input  wire logic                         set_mask,
    input  wire logic                         clr_mask,
    output logic                              condition_code_reg_i,
    output logic                              push_valid,
    output logic                              pop_valid,
    output logic [2:0]                        frame_sel,
    output logic                              vec_load,
    output logic [15:0]                       program_counter_vec,
    output logic [15:0]                       reset_vec,
    // Power modes
    input  wire logic                         wait_mode,
    input  wire logic                         halt_mode,
    input  wire logic                         active_halt,
    output logic                              wake_wait,
    output logic                              wake_halt,
    // Peripheral events and clear sequences
    input  wire logic [PERIPHS-1:0]           periph_evt,
    input  wire logic [PERIPHS-1:0]           periph_seq_clr,
    // External interrupt pins
    input  wire logic [GROUPS*GRP_PINS-1:0]   ext_pin
);
    localparam int NPIN = GROUPS * GRP_PINS;

    // ==========================================================================
    // Helpers
    function automatic logic [3:0] vic_pick(input logic [13:0] r);
        logic [3:0] p;
        p = `VIC_VEC_NONE;
        for (int i = 13; i >= 1; i--) begin
            if (r[i]) begin
                p = 4'(i);
            end
        end
        return p;
    endfunction
    function automatic logic [15:0] vic_addr(input logic [3:0] n);
        logic [15:0] a;
        a = `VIC_ADDR_BASE - {11'h000, n, 1'b0};
        if (n == `VIC_VEC_TRAP) begin
            a = `VIC_ADDR_TRAP;
        end
        return a;
    endfunction

    // ==========================================================================
    // Register bus
    logic                ap_r, ap_wr_r, rd_done_r;
    logic [7:0]          ap_addr_r;
    logic [31:0]         hrdata_r, rd_mux;
    logic [7:0]          sens_r;
    logic [NPIN-1:0]     pin_en_r;
    logic [PERIPHS-1:0]  pen_r, pflag_r;
    wire                 accept  = hsel & htrans[1] & hready;
    wire                 wr_cyc  = ap_r & ap_wr_r;
    wire                 wr_sens = wr_cyc & (ap_addr_r == `VIC_OFF_EXT_SENS);
    wire                 wr_pin  = wr_cyc & (ap_addr_r == `VIC_OFF_PIN_EN);
    wire                 wr_pen  = wr_cyc & (ap_addr_r == `VIC_OFF_PERIPH_EN);
    wire                 wr_flg  = wr_cyc & (ap_addr_r == `VIC_OFF_PERIPH_FLG);
    // Reads take one wait state so a write just before is always seen
    assign hreadyout = ~(ap_r & ~ap_wr_r & ~rd_done_r);
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_r;
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            ap_r      <= 1'b0;
            ap_wr_r   <= 1'b0;
            ap_addr_r <= 8'h00;
            rd_done_r <= 1'b0;
            hrdata_r  <= 32'h0000_0000;
        end else begin
            ap_r      <= accept | (ap_r & ~hreadyout);
            rd_done_r <= ap_r & ~ap_wr_r & ~rd_done_r;
            if (accept) begin
                ap_wr_r   <= hwrite;
                ap_addr_r <= haddr;
            end
            if (ap_r & ~ap_wr_r & ~rd_done_r) begin
                hrdata_r <= rd_mux;
            end
        end
    end
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            sens_r   <= `VIC_RST_EXT_SENS;
            pin_en_r <= NPIN'(`VIC_RST_PIN_EN);
            pen_r    <= `VIC_RST_PERIPH_EN;
        end else begin
            if (wr_sens) begin
                sens_r <= hwdata[7:0];
            end
            if (wr_pin) begin
                pin_en_r <= hwdata[NPIN-1:0];
            end
            if (wr_pen) begin
                pen_r <= hwdata[PERIPHS-1:0];
            end
        end
    end

    // ==========================================================================
    // Peripheral flags
    // A new event in the clearing cycle survives the clear
    wire [PERIPHS-1:0] flg_wclr = wr_flg ? ~hwdata[PERIPHS-1:0] : '0;
    wire [PERIPHS-1:0] flg_nxt  = (pflag_r & ~(flg_wclr | periph_seq_clr)) | periph_evt;
    wire [PERIPHS-1:0] preq     = pflag_r & pen_r;
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            pflag_r <= '0;
        end else begin
            pflag_r <= flg_nxt;
        end
    end

    // ==========================================================================
    // External pins: three-stage synchroniser and agreement filter
    logic [NPIN-1:0]   s1_r, s2_r, s3_r, flt_r;
    logic [GROUPS-1:0] comb_d_r, el_r;
    logic [GROUPS-1:0] grp_on, comb, rise, fall, det, lvl, ext_req, el_clr;
    wire  [NPIN-1:0]   agree   = ~(s2_r ^ s3_r);
    wire  [NPIN-1:0]   flt_nxt = (agree & s3_r) | (~agree & flt_r);
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            s1_r  <= '1;
            s2_r  <= '1;
            s3_r  <= '1;
            flt_r <= '1;
        end else begin
            s1_r  <= ext_pin;
            s2_r  <= s1_r;
            s3_r  <= s2_r;
            flt_r <= flt_nxt;
        end
    end
    always_comb begin
        for (int g = 0; g < GROUPS; g++) begin
            logic [GRP_PINS-1:0] en_g, pin_g;
            logic [1:0]          sel;
            en_g  = pin_en_r[g*GRP_PINS +: GRP_PINS];
            pin_g = flt_r[g*GRP_PINS +: GRP_PINS];
            sel   = sens_r[2*g +: 2];
            grp_on[g] = |en_g;
            // Disabled pins count as high, so any low enabled pin pins the output high
            comb[g] = ~&(pin_g | ~en_g);
            rise[g] = comb[g] & ~comb_d_r[g];
            fall[g] = ~comb[g] & comb_d_r[g];
            lvl[g]  = (sel == `VIC_SENS_LOW);
            det[g]  = grp_on[g] & ((sel == `VIC_SENS_RISE) ? rise[g] :
                                   (sel == `VIC_SENS_FALL) ? fall[g] :
                                   (sel == `VIC_SENS_BOTH) ? (rise[g] | fall[g]) : 1'b0);
            ext_req[g] = grp_on[g] & (lvl[g] ? ~comb[g] : el_r[g]);
        end
    end

    // ==========================================================================
    // Request vector and selection
    logic [13:0] req;
    logic [3:0]  pick;
    assign req  = {2'b00, preq[6:2], 1'b0, ext_req,
                   preq[1] | preq[0], 1'b0} & ~`VIC_UNUSED_SLOTS;
    assign pick = vic_pick(req);

    // ==========================================================================
    // Entry and return sequencer
    vic_pkg::vic_state_type st_r, st_nxt;
    logic [2:0] cnt_r;
    logic [3:0] vec_r;
    logic       i_bit_r, trap_pend_r;
    wire        can_take = trap_pend_r | (~i_bit_r & (|req));
    wire        entry    = (st_r == vic_pkg::VIC_IDLE) & instr_end & can_take;
    wire        ret      = (st_r == vic_pkg::VIC_IDLE) & ~entry & return_from_irq_instr_exec;
    wire        last     = (cnt_r == `VIC_FRAME_LAST);
    wire        pop_done = (st_r == vic_pkg::VIC_POP) & last;
    wire        trap_go  = entry & trap_pend_r;
    wire [3:0]  vec_nxt  = trap_pend_r ? `VIC_VEC_TRAP : pick;
    always_comb begin
        st_nxt = st_r;
        case (st_r)
            vic_pkg::VIC_IDLE: begin
                if (entry) begin
                    st_nxt = vic_pkg::VIC_PUSH;
                end else if (ret) begin
                    st_nxt = vic_pkg::VIC_POP;
                end
            end
            vic_pkg::VIC_PUSH: begin
                if (last) begin
                    st_nxt = vic_pkg::VIC_VECT;
                end
            end
            vic_pkg::VIC_VECT: begin
                st_nxt = vic_pkg::VIC_IDLE;
            end
            vic_pkg::VIC_POP: begin
                if (last) begin
                    st_nxt = vic_pkg::VIC_IDLE;
                end
            end
            default: begin
                st_nxt = vic_pkg::VIC_IDLE;
            end
        endcase
    end
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_r  <= vic_pkg::VIC_IDLE;
            cnt_r <= 3'h0;
            vec_r <= `VIC_VEC_NONE;
        end else begin
            st_r  <= st_nxt;
            cnt_r <= (st_nxt == st_r) ? cnt_r + 3'h1 : 3'h0;
            if (entry) begin
                vec_r <= vec_nxt;
            end
        end
    end

    // Mask bit: entry and set win over any clear in the same cycle
    wire i_set = entry | set_mask;
    wire i_clr = pop_done | clr_mask;
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            i_bit_r     <= 1'b1;
            trap_pend_r <= 1'b0;
        end else begin
            i_bit_r     <= i_set | (i_bit_r & ~i_clr);
            trap_pend_r <= trap_exec | (trap_pend_r & ~trap_go);
        end
    end

    // Edge latches clear on entering their own vector; a fresh edge still wins
    always_comb begin
        for (int g = 0; g < GROUPS; g++) begin
            el_clr[g] = (st_r == vic_pkg::VIC_VECT) & (vec_r == `VIC_VEC_EXT0 + 4'(g));
        end
    end
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            el_r     <= '0;
            comb_d_r <= '0;
        end else begin
            el_r     <= det | (el_r & ~el_clr & ~lvl);
            comb_d_r <= comb;
        end
    end

    // ==========================================================================
    // Core-facing outputs
    logic vec_load_r, push_r, pop_r;
    logic [2:0]  sel_r;
    logic [15:0] pc_vec_r;
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            vec_load_r <= 1'b0;
            push_r     <= 1'b0;
            pop_r      <= 1'b0;
            sel_r      <= 3'h0;
            pc_vec_r   <= `VIC_ADDR_RESET;
        end else begin
            vec_load_r <= (st_nxt == vic_pkg::VIC_VECT);
            push_r     <= (st_nxt == vic_pkg::VIC_PUSH);
            pop_r      <= (st_nxt == vic_pkg::VIC_POP);
            sel_r      <= (st_nxt == st_r) ? cnt_r + 3'h1 : 3'h0;
            if (st_nxt == vic_pkg::VIC_VECT) begin
                pc_vec_r <= vic_addr(vec_r);
            end
        end
    end

    assign vec_load             = vec_load_r;
    assign push_valid           = push_r;
    assign pop_valid            = pop_r;
    assign frame_sel            = sel_r;
    assign program_counter_vec  = pc_vec_r;
    assign reset_vec            = `VIC_ADDR_RESET;
    assign condition_code_reg_i = i_bit_r;

    // ==========================================================================
    // Wake-up from low-power modes; trap never wakes from halt
    wire halt_src = (|ext_req) | (active_halt & req[1]);
    assign wake_wait = wait_mode & (|req);
    assign wake_halt = halt_mode & halt_src;

    // ==========================================================================
    // Status read mux
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (ap_addr_r == `VIC_OFF_EXT_SENS) begin
            rd_mux[7:0] = sens_r;
        end else if (ap_addr_r == `VIC_OFF_PIN_EN) begin
            rd_mux[NPIN-1:0] = pin_en_r;
        end else if (ap_addr_r == `VIC_OFF_PERIPH_EN) begin
            rd_mux[PERIPHS-1:0] = pen_r;
        end else if (ap_addr_r == `VIC_OFF_PERIPH_FLG) begin
            rd_mux[PERIPHS-1:0] = pflag_r;
        end else if (ap_addr_r == `VIC_OFF_STATUS) begin
            rd_mux[9:0] = {el_r, trap_pend_r, i_bit_r, pick};
        end
    end

    // ==========================================================================
    // Assertions
    mask_gate_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        entry && !trap_pend_r |-> !i_bit_r && req != 14'h0000)
        else $error("maskable entry while masked");
    boundary_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        entry |-> instr_end)
        else $error("entry off an instruction boundary");
    frame_push_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        entry |=> push_valid [*5] ##1 (vec_load && !push_valid))
        else $error("stack frame not five pushes then vector");
    mask_set_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        entry |=> condition_code_reg_i [*6])
        else $error("mask bit not held through entry");
    vector_addr_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        vec_load && vec_r == `VIC_VEC_CLK |-> program_counter_vec == 16'hFFF8)
        else $error("wrong vector address");
    return_from_irq_instr_clear_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        ret && !set_mask |=> pop_valid [*5] ##1 !condition_code_reg_i)
        else $error("return did not pop and unmask");
    priority_sel_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        entry && !trap_pend_r |=> vec_r == $past(pick) && !$past(req[1]) || vec_r == 4'h1)
        else $error("priority order broken");
    trap_take_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        trap_go |-> ##6 (vec_load && program_counter_vec == `VIC_ADDR_TRAP))
        else $error("trap vector not loaded");
    halt_wake_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        wake_halt && !active_halt |-> ext_req != '0)
        else $error("full halt woken by non-external source");
    edge_clr_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        el_clr[0] && !det[0] |=> !el_r[0])
        else $error("edge latch not cleared on entry");
    flag_drop_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        periph_seq_clr[2] && !periph_evt[2] |=> !pflag_r[2] && !req[7])
        else $error("cleared flag still requests");
    unused_slot_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        !req[0] && !req[6] && !req[12] && !req[13])
        else $error("unused slot requested");

    trap_c: cover property (@(posedge core_clk) disable iff (!arst_n) trap_go);
    ext_c: cover property (@(posedge core_clk) disable iff (!arst_n)
        entry && vec_nxt == `VIC_VEC_EXT3);
    ret_c: cover property (@(posedge core_clk) disable iff (!arst_n) pop_done);
    wake_c: cover property (@(posedge core_clk) disable iff (!arst_n) wake_halt);
endmodule
`default_nettype wire

//--- bench/vic_core_model.sv
// Purpose: Core model that answers entry sequences
// Assumes: One frame of pushes precedes each vector load
// Notes:   Two busy cycles after a vector load stand for a slow first instruction
`default_nettype none
module vic_core_model (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        arst_n,
    // Sequencer side
    input  wire logic        push_valid,
    input  wire logic        vec_load,
    input  wire logic [15:0] program_counter_vec,
    // Observations
    output logic             instr_end,
    output logic [15:0]      last_vec,
    output logic [3:0]       last_len,
    output logic [7:0]       vec_cnt
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] run_r;
    logic [1:0] busy_r;
    // ==========================================================
    // Boundary and frame bookkeeping
    // Entry must wait while the first routine instruction runs
    assign instr_end = (busy_r == 2'h0);
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            run_r    <= 4'h0;
            busy_r   <= 2'h0;
            last_vec <= 16'h0000;
            last_len <= 4'h0;
            vec_cnt  <= 8'h00;
        end else if (vec_load) begin
            last_vec <= program_counter_vec;
            last_len <= run_r;
            vec_cnt  <= vec_cnt + 8'h01;
            run_r    <= 4'h0;
            busy_r   <= 2'h2;
        end else begin
            busy_r <= (busy_r == 2'h0) ? 2'h0 : busy_r - 2'h1;
            run_r  <= push_valid ? run_r + 4'h1 : run_r;
        end
    end
endmodule
`default_nettype wire

//--- bench/vic_top_test.sv
// Purpose: Self-checking bench of the interrupt control
// Assumes: hready is fed back from hreadyout
// Notes:   Rows walk every source; awkward cases follow by hand
`include "vic_defines.svh"
`default_nettype none
module vic_top_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 1'b0, arst_n = 1'b0, hsel = 1'b0, hwr = 1'b0, rdy, hresp, mask, vl, ww, wh, ie;
    logic [7:0]  ha = 8'h00, vcnt, c;
    logic [1:0]  ht = 2'h0;
    logic [31:0] hwd = 32'h0000_0000, hrd, rd;
    logic [3:0]  ctl = 4'h0, llen;
    logic [6:0]  evt = 7'h00, sclr = 7'h00;
    logic [2:0]  pm = 3'h0, fs;
    logic [15:0] pins = 16'hFFFD, pcv, lvec, rvec;
    logic        pv, pop;
    int          error_cnt = 0, compares = 0;
    int          src [11] = '{0, 1, 2, 3, 4, 5, 6, 8, 9, 10, 11};
    logic [15:0] vec [11] = '{16'hFFF8, 16'hFFF8, 16'hFFEC, 16'hFFEA, 16'hFFE8, 16'hFFE6,
                              16'hFFE4, 16'hFFF6, 16'hFFF4, 16'hFFF2, 16'hFFF0};
    always #20 clk = ~clk;
    vic_top vic_top_inst (.core_clk(clk), .arst_n(arst_n), .hsel(hsel), .haddr(ha), .htrans(ht),
        .hwrite(hwr), .hsize(3'h2), .hwdata(hwd), .hready(rdy), .hreadyout(rdy), .hresp(hresp),
        .hrdata(hrd), .instr_end(ie), .trap_exec(ctl[0]), .return_from_irq_instr_exec(ctl[1]), .set_mask(ctl[2]),
        .clr_mask(ctl[3]), .condition_code_reg_i(mask), .push_valid(pv), .pop_valid(pop),
        .frame_sel(fs), .vec_load(vl), .program_counter_vec(pcv), .reset_vec(rvec),
        .wait_mode(pm[0]), .halt_mode(pm[1]), .active_halt(pm[2]), .wake_wait(ww),
        .wake_halt(wh), .periph_evt(evt), .periph_seq_clr(sclr), .ext_pin(pins));
    vic_core_model vic_core_model_inst (.core_clk(clk), .arst_n(arst_n), .push_valid(pv),
        .vec_load(vl), .program_counter_vec(pcv), .instr_end(ie), .last_vec(lvec),
        .last_len(llen), .vec_cnt(vcnt));
    // ==========================================================
    // Shared tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Ready and read data are taken at the rising edge where ready is high
    task automatic wait_rdy();
        do begin
            @(posedge clk);
        end while (rdy !== 1'b1);
        rd = hrd;
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        ht <= 2'h2;
        ha <= a;
        hwr <= w;
        wait_rdy();
        hsel <= 1'b0;
        ht <= 2'h0;
        hwd <= d;
        wait_rdy();
    endtask
    task automatic pulse(input logic [3:0] k, input logic [6:0] e, input logic [6:0] s);
        ctl <= k;
        evt <= e;
        sclr <= s;
        @(posedge clk);
        ctl <= 4'h0;
        evt <= 7'h00;
        sclr <= 7'h00;
        @(posedge clk);
    endtask
    task automatic mode(input logic [2:0] m, input logic wake);
        pm <= m;
        @(negedge clk);
        chk(32'({ww, wh}), 32'({m[0], wake}));
        @(posedge clk);
    endtask
    task automatic entry(input logic [15:0] ea);
        logic [7:0]  c0;
        int          n;
        c0 = vcnt;
        n = 0;
        while (vcnt === c0 && n < 80) begin
            @(posedge clk);
            n++;
        end
        @(negedge clk);
        chk(32'(vcnt), 32'(c0 + 8'h01));
        chk(32'(lvec), 32'(ea));
        chk(32'({llen, mask}), 32'h0B);
        @(posedge clk);
    endtask
    // Edge latches left armed would re-enter and hold the mask up
    task automatic leave();
        pulse(4'h2, 7'h00, 7'h00);
        @(negedge clk);
        chk(32'({pop, fs}), 32'h9);
        repeat (9) @(posedge clk);
        chk(32'(mask), 32'h0);
    endtask
    task automatic final_report();
        $display("Compares %0d, mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        #400000;
        error_cnt++;
        final_report();
    end
    // ==========================================================
    // Main sequence
    initial begin
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        @(negedge clk);
        chk(32'({hresp, mask, pcv}), 32'h1_FFFE);
        chk(32'(rvec), 32'hFFFE);
        @(posedge clk);
        bus(1'b1, 8'h40, 32'hFFFF_FFFF);
        bus(1'b0, `VIC_OFF_PERIPH_EN, 32'h0);
        chk(rd, 32'h0);
        bus(1'b1, `VIC_OFF_PIN_EN, 32'h3);
        bus(1'b1, `VIC_OFF_EXT_SENS, 32'h55);
        pins[0] <= 1'b0;
        repeat (6) @(posedge clk);
        pins[0] <= 1'b1;
        repeat (6) @(posedge clk);
        bus(1'b0, `VIC_OFF_STATUS, 32'h0);
        chk(rd & 32'h3CF, 32'h0);
        bus(1'b1, `VIC_OFF_EXT_SENS, 32'h57);
        pins[1] <= 1'b1;
        repeat (6) @(posedge clk);
        bus(1'b0, `VIC_OFF_STATUS, 32'h0);
        chk(rd & 32'h1F, 32'h12);
        bus(1'b1, `VIC_OFF_EXT_SENS, 32'h55);
        bus(1'b1, `VIC_OFF_PIN_EN, 32'h0);
        for (int i = 0; i < 11; i++) begin
            pulse(4'h4, 7'h00, 7'h00);
            if (src[i] < 7) begin
                bus(1'b1, `VIC_OFF_PERIPH_EN, 32'h1 << src[i]);
                pulse(4'h0, 7'(1 << src[i]), 7'h00);
            end else begin
                bus(1'b1, `VIC_OFF_PIN_EN, 32'h1 << (4 * (src[i] - 8)));
                pins[4 * (src[i] - 8)] <= 1'b0;
            end
            c = vcnt;
            repeat (12) @(posedge clk);
            chk(32'(vcnt), 32'(c));
            pulse(4'h8, 7'h00, 7'h00);
            entry(vec[i]);
            if (src[i] < 7) begin
                bus(1'b1, `VIC_OFF_PERIPH_FLG, 32'h0);
            end else begin
                pins <= 16'hFFFF;
                repeat (6) @(posedge clk);
                bus(1'b1, `VIC_OFF_PIN_EN, 32'h0);
            end
            leave();
        end
        pulse(4'h4, 7'h00, 7'h00);
        bus(1'b1, `VIC_OFF_PERIPH_EN, 32'h7F);
        pulse(4'h0, 7'h18, 7'h00);
        mode(3'h1, 1'b0);
        mode(3'h2, 1'b0);
        mode(3'h0, 1'b0);
        pulse(4'h8, 7'h00, 7'h00);
        entry(16'hFFEA);
        bus(1'b1, `VIC_OFF_PERIPH_FLG, 32'h77);
        pulse(4'h2, 7'h00, 7'h00);
        entry(16'hFFE8);
        bus(1'b1, `VIC_OFF_PERIPH_FLG, 32'h0);
        leave();
        pulse(4'h4, 7'h00, 7'h00);
        pulse(4'h0, 7'h06, 7'h00);
        mode(3'h2, 1'b0);
        mode(3'h6, 1'b1);
        mode(3'h0, 1'b0);
        pulse(4'h0, 7'h00, 7'h06);
        bus(1'b0, `VIC_OFF_STATUS, 32'h0);
        chk(rd & 32'hF, 32'h0);
        pulse(4'h1, 7'h00, 7'h00);
        entry(`VIC_ADDR_TRAP);
        leave();
        final_report();
    end
endmodule
`default_nettype wire
